// ==== logic/ecd_defs.svh ====
// constants of the eight-bit core datapath: addresses, field positions, reset values
`ifndef ECD_DEFS_SVH
`define ECD_DEFS_SVH
`define ECD_ADR_INDW    5'h00
`define ECD_ADR_PCL     5'h02
`define ECD_ADR_STAT    5'h03
`define ECD_ADR_PTR     5'h04
`define ECD_ST_C        0
`define ECD_ST_DC       1
`define ECD_ST_Z        2
`define ECD_ST_PA       5
`define ECD_FL_C        3'h1
`define ECD_FL_Z        3'h4
`define ECD_FL_ALL      3'h7
`define ECD_STAT_RST    8'h18
`define ECD_PTR_RST     5'h00
`define ECD_PTR_PAD     3'h7
`define ECD_NOP         12'h000
`define ECD_BUS_MEM_TOP 8'h1f
`define ECD_BUS_CTRL    8'h20
`define ECD_BUS_STATE   8'h21
`define ECD_CTRL_RST    1'b1
`endif

// ==== logic/ecd_pkg.sv ====
// types of the eight-bit core datapath
package ecd_pkg;
	typedef enum logic [3:0] {
		ECD_ALU_ADD   = 4'h0,
		ECD_ALU_SUB   = 4'h1,
		ECD_ALU_AND   = 4'h2,
		ECD_ALU_OR    = 4'h3,
		ECD_ALU_XOR   = 4'h4,
		ECD_ALU_COM   = 4'h5,
		ECD_ALU_INC   = 4'h6,
		ECD_ALU_DEC   = 4'h7,
		ECD_ALU_RR    = 4'h8,
		ECD_ALU_RL    = 4'h9,
		ECD_ALU_SWAP  = 4'ha,
		ECD_ALU_PASSA = 4'hb,
		ECD_ALU_PASSB = 4'hc,
		ECD_ALU_ZERO  = 4'hd
	} ecd_alu_op_t;
	typedef enum logic [5:0] {
		ECD_BY_MISC  = 6'h00,
		ECD_BY_CLR   = 6'h01,
		ECD_BY_SUB   = 6'h02,
		ECD_BY_DEC   = 6'h03,
		ECD_BY_OR    = 6'h04,
		ECD_BY_AND   = 6'h05,
		ECD_BY_XOR   = 6'h06,
		ECD_BY_ADD   = 6'h07,
		ECD_BY_MOV   = 6'h08,
		ECD_BY_COM   = 6'h09,
		ECD_BY_INC   = 6'h0a,
		ECD_BY_DECSZ = 6'h0b,
		ECD_BY_RR    = 6'h0c,
		ECD_BY_RL    = 6'h0d,
		ECD_BY_SWAP  = 6'h0e,
		ECD_BY_INCSZ = 6'h0f
	} ecd_byte_op_t;
	typedef enum logic [3:0] {
		ECD_TOP_BITCLR  = 4'h4,
		ECD_TOP_BITSET  = 4'h5,
		ECD_TOP_SKIPCLR = 4'h6,
		ECD_TOP_SKIPSET = 4'h7,
		ECD_TOP_RETLIT  = 4'h8,
		ECD_TOP_CALL    = 4'h9,
		ECD_TOP_JUMP0   = 4'ha,
		ECD_TOP_JUMP1   = 4'hb,
		ECD_TOP_LOADLIT = 4'hc,
		ECD_TOP_ORLIT   = 4'hd,
		ECD_TOP_ANDLIT  = 4'he,
		ECD_TOP_XORLIT  = 4'hf
	} ecd_top_op_t;
	typedef enum logic {
		ECD_PIPE_EXEC  = 1'b0,
		ECD_PIPE_FLUSH = 1'b1
	} ecd_pipe_t;
endpackage

// ==== logic/ecd_if.sv ====
// carriers between the core and its alu and data memory
interface ecd_alu_if;
	logic [7:0]                a;
	logic [7:0]                b;
	logic [7:0]                y;
	ecd_pkg::ecd_alu_op_t      op;
	logic                      cin;
	logic                      c;
	logic                      dc;
	logic                      z;
	modport alu (input a, b, op, cin, output y, c, dc, z);
	modport core (output a, b, op, cin, input y, c, dc, z);
endinterface

interface ecd_mem_if;
	logic       we;
	logic [4:0] waddr;
	logic [7:0] wdata;
	logic [4:0] raddr;
	logic [7:0] rdata;
	logic [4:0] baddr;
	logic [7:0] brdata;
	modport mem (input we, waddr, wdata, raddr, baddr, output rdata, brdata);
	modport core (output we, waddr, wdata, raddr, baddr, input rdata, brdata);
endinterface

// ==== logic/ecd_alu.sv ====
// eight-bit alu with carry, half-carry and zero
module ecd_alu (
	ecd_alu_if.alu port
);
	logic       sub;
	logic [7:0] b2;
	logic [8:0] sum;
	logic [4:0] nib;

	// subtract as a + ~b + 1, so carries come out as inverted borrows
	assign sub = (port.op == ecd_pkg::ECD_ALU_SUB);
	assign b2  = sub ? ~port.b : port.b;
	assign sum = {1'b0, port.a} + {1'b0, b2} + {8'h00, sub};
	assign nib = {1'b0, port.a[3:0]} + {1'b0, b2[3:0]} + {4'h0, sub};

	always_comb begin
		port.c = sum[8];
		case (port.op)
			ecd_pkg::ECD_ALU_ADD,
			ecd_pkg::ECD_ALU_SUB:   port.y = sum[7:0];
			ecd_pkg::ECD_ALU_AND:   port.y = port.a & port.b;
			ecd_pkg::ECD_ALU_OR:    port.y = port.a | port.b;
			ecd_pkg::ECD_ALU_XOR:   port.y = port.a ^ port.b;
			ecd_pkg::ECD_ALU_COM:   port.y = ~port.a;
			ecd_pkg::ECD_ALU_INC:   port.y = port.a + 8'h01;
			ecd_pkg::ECD_ALU_DEC:   port.y = port.a - 8'h01;
			ecd_pkg::ECD_ALU_RR: begin
				port.y = {port.cin, port.a[7:1]};
				port.c = port.a[0];
			end
			ecd_pkg::ECD_ALU_RL: begin
				port.y = {port.a[6:0], port.cin};
				port.c = port.a[7];
			end
			ecd_pkg::ECD_ALU_SWAP:  port.y = {port.a[3:0], port.a[7:4]};
			ecd_pkg::ECD_ALU_PASSA: port.y = port.a;
			ecd_pkg::ECD_ALU_PASSB: port.y = port.b;
			default:                port.y = 8'h00;
		endcase
	end

	assign port.dc = nib[4];
	assign port.z  = (port.y == 8'h00);
endmodule

// ==== logic/ecd_regfile.sv ====
// data memory cells, one write port and two read ports
module ecd_regfile #(
	parameter int DEPTH = 32
) (
	input logic clk,
	input logic rst,
	ecd_mem_if.mem port
);
	logic [7:0] cell_ff [DEPTH];

	always_ff @(posedge clk) begin
		if (rst) begin
			for (int i = 0; i < DEPTH; i++) begin
				cell_ff[i] <= 8'h00;
			end
		end else if (port.we) begin
			cell_ff[port.waddr] <= port.wdata;
		end
	end

	assign port.rdata  = cell_ff[port.raddr];
	assign port.brdata = cell_ff[port.baddr];
endmodule

// ==== logic/ecd_core.sv ====
// eight-bit core: fetch/execute pipeline, decode, special registers, debug port
`include "ecd_defs.svh"
module ecd_core #(
	parameter int PC_W = 9
) (
	input  logic            clk,
	input  logic            rst,
	output logic [PC_W-1:0] prog_addr,
	output logic            prog_rd_en,
	input  logic [11:0]     prog_instr,
	input  logic [7:0]      bus_addr,
	input  logic [7:0]      bus_wdata,
	input  logic            bus_wr,
	input  logic            bus_rd,
	output logic [7:0]      bus_rdata
);
	ecd_alu_if alu ();
	ecd_mem_if mem ();

	ecd_alu u_alu (
		.port (alu.alu)
	);

	ecd_regfile #(
		.DEPTH (32)
	) u_regfile (
		.clk  (clk),
		.rst  (rst),
		.port (mem.mem)
	);

	// architectural state
	logic [11:0]        instr_ff;
	ecd_pkg::ecd_pipe_t pipe_ff;
	logic [PC_W-1:0]    ip_ff;
	logic [PC_W-1:0]    stk0_ff;
	logic [PC_W-1:0]    stk1_ff;
	logic [7:0]         w_ff;
	logic [7:0]         stat_ff;
	logic [4:0]         ptr_ff;
	logic               run_ff;

	// next values
	logic [7:0]         nxt_w;
	logic [7:0]         nxt_stat;
	logic [4:0]         nxt_ptr;
	logic [PC_W-1:0]    nxt_ip;
	logic [7:0]         nxt_rdata;

	// decode
	logic [4:0]         fsel;
	logic [4:0]         eff;
	logic [7:0]         fdata;
	logic [7:0]         lit;
	logic [2:0]         bitn;
	logic [7:0]         bmask;
	logic               is_byte;
	logic               is_bit;
	logic               exec;
	logic [PC_W-1:0]    ip_inc;
	logic [1:0]         page;
	logic               core_we;
	logic               bus_we;
	logic [7:0]         bus_val;

	// decode results
	ecd_pkg::ecd_alu_op_t op;
	logic [7:0]         opa;
	logic [2:0]         fl;
	logic               wr_f;
	logic               wr_w;
	logic               skip;
	logic               jmp;
	logic [PC_W-1:0]    tgt;
	logic               push;
	logic               pop;

	// page bits sit above bits 8:0; narrower variants simply drop them
	function automatic logic [PC_W-1:0] pc_full(input logic [1:0] pa, input logic [8:0] lo);
		logic [10:0] t;
		t = {pa, lo};
		pc_full = t[PC_W-1:0];
	endfunction

	function automatic logic is_sfr(input logic [4:0] a);
		is_sfr = (a == `ECD_ADR_INDW) || (a == `ECD_ADR_PCL) ||
			(a == `ECD_ADR_STAT) || (a == `ECD_ADR_PTR);
	endfunction

	// accumulator deliberately has no case here
	function automatic logic [7:0] rd_loc(input logic [4:0] a, input logic [7:0] m,
		input logic [7:0] pcl, input logic [7:0] st, input logic [4:0] pt);
		case (a)
			`ECD_ADR_INDW: rd_loc = 8'h00;
			`ECD_ADR_PCL:  rd_loc = pcl;
			`ECD_ADR_STAT: rd_loc = st;
			`ECD_ADR_PTR:  rd_loc = {`ECD_PTR_PAD, pt};
			default:       rd_loc = m;
		endcase
	endfunction

	// fetch side: own port, independent of data memory, one word a cycle
	assign prog_addr  = ip_ff;
	assign prog_rd_en = run_ff;
	assign ip_inc     = ip_ff + PC_W'(1);
	assign page       = stat_ff[`ECD_ST_PA+1:`ECD_ST_PA];

	assign exec    = (pipe_ff == ecd_pkg::ECD_PIPE_EXEC);
	assign is_byte = (instr_ff[11:10] == 2'b00);
	assign is_bit  = (instr_ff[11:10] == 2'b01);
	assign fsel    = instr_ff[4:0];
	assign lit     = instr_ff[7:0];
	assign bitn    = instr_ff[7:5];
	assign bmask   = 8'h01 << bitn;

	// window register redirects through the pointer
	assign eff   = (fsel == `ECD_ADR_INDW) ? ptr_ff : fsel;
	assign fdata = rd_loc(eff, mem.rdata, ip_ff[7:0], stat_ff, ptr_ff);
	assign mem.raddr = eff;

	// operand a is register, bit-modified register or literal; b is the accumulator
	assign alu.a   = opa;
	assign alu.b   = w_ff;
	assign alu.op  = op;
	assign alu.cin = stat_ff[`ECD_ST_C];

	always_comb begin
		op   = ecd_pkg::ECD_ALU_PASSA;
		opa  = fdata;
		fl   = 3'h0;
		wr_f = 1'b0;
		wr_w = 1'b0;
		skip = 1'b0;
		jmp  = 1'b0;
		tgt  = ip_inc;
		push = 1'b0;
		pop  = 1'b0;
		if (exec && is_byte) begin
			wr_f = instr_ff[5];
			wr_w = !instr_ff[5];
			case (ecd_pkg::ecd_byte_op_t'(instr_ff[11:6]))
				ecd_pkg::ECD_BY_MISC: begin
					op   = ecd_pkg::ECD_ALU_PASSB;
					wr_w = 1'b0;
				end
				ecd_pkg::ECD_BY_CLR: begin
					op = ecd_pkg::ECD_ALU_ZERO;
					fl = `ECD_FL_Z;
				end
				ecd_pkg::ECD_BY_SUB: begin
					op = ecd_pkg::ECD_ALU_SUB;
					fl = `ECD_FL_ALL;
				end
				ecd_pkg::ECD_BY_ADD: begin
					op = ecd_pkg::ECD_ALU_ADD;
					fl = `ECD_FL_ALL;
				end
				ecd_pkg::ECD_BY_DEC: begin
					op = ecd_pkg::ECD_ALU_DEC;
					fl = `ECD_FL_Z;
				end
				ecd_pkg::ECD_BY_OR: begin
					op = ecd_pkg::ECD_ALU_OR;
					fl = `ECD_FL_Z;
				end
				ecd_pkg::ECD_BY_AND: begin
					op = ecd_pkg::ECD_ALU_AND;
					fl = `ECD_FL_Z;
				end
				ecd_pkg::ECD_BY_XOR: begin
					op = ecd_pkg::ECD_ALU_XOR;
					fl = `ECD_FL_Z;
				end
				ecd_pkg::ECD_BY_MOV: fl = `ECD_FL_Z;
				ecd_pkg::ECD_BY_COM: begin
					op = ecd_pkg::ECD_ALU_COM;
					fl = `ECD_FL_Z;
				end
				ecd_pkg::ECD_BY_INC: begin
					op = ecd_pkg::ECD_ALU_INC;
					fl = `ECD_FL_Z;
				end
				ecd_pkg::ECD_BY_DECSZ: begin
					op   = ecd_pkg::ECD_ALU_DEC;
					skip = alu.z;
				end
				ecd_pkg::ECD_BY_INCSZ: begin
					op   = ecd_pkg::ECD_ALU_INC;
					skip = alu.z;
				end
				ecd_pkg::ECD_BY_RR: begin
					op = ecd_pkg::ECD_ALU_RR;
					fl = `ECD_FL_C;
				end
				ecd_pkg::ECD_BY_RL: begin
					op = ecd_pkg::ECD_ALU_RL;
					fl = `ECD_FL_C;
				end
				ecd_pkg::ECD_BY_SWAP: op = ecd_pkg::ECD_ALU_SWAP;
				default: op = ecd_pkg::ECD_ALU_PASSA;
			endcase
		end else if (exec && is_bit) begin
			case (ecd_pkg::ecd_top_op_t'(instr_ff[11:8]))
				ecd_pkg::ECD_TOP_BITCLR: begin
					opa  = fdata & ~bmask;
					wr_f = 1'b1;
				end
				ecd_pkg::ECD_TOP_BITSET: begin
					opa  = fdata | bmask;
					wr_f = 1'b1;
				end
				ecd_pkg::ECD_TOP_SKIPCLR: skip = !fdata[bitn];
				default: skip = fdata[bitn];
			endcase
		end else if (exec) begin
			opa = lit;
			case (ecd_pkg::ecd_top_op_t'(instr_ff[11:8]))
				ecd_pkg::ECD_TOP_RETLIT: begin
					wr_w = 1'b1;
					pop  = 1'b1;
					jmp  = 1'b1;
					tgt  = stk0_ff;
				end
				ecd_pkg::ECD_TOP_CALL: begin
					push = 1'b1;
					jmp  = 1'b1;
					tgt  = pc_full(page, {1'b0, lit});
				end
				ecd_pkg::ECD_TOP_JUMP0,
				ecd_pkg::ECD_TOP_JUMP1: begin
					jmp = 1'b1;
					tgt = pc_full(page, instr_ff[8:0]);
				end
				ecd_pkg::ECD_TOP_LOADLIT: wr_w = 1'b1;
				ecd_pkg::ECD_TOP_ORLIT: begin
					op   = ecd_pkg::ECD_ALU_OR;
					fl   = `ECD_FL_Z;
					wr_w = 1'b1;
				end
				ecd_pkg::ECD_TOP_ANDLIT: begin
					op   = ecd_pkg::ECD_ALU_AND;
					fl   = `ECD_FL_Z;
					wr_w = 1'b1;
				end
				default: begin
					op   = ecd_pkg::ECD_ALU_XOR;
					fl   = `ECD_FL_Z;
					wr_w = 1'b1;
				end
			endcase
		end
		// writing the pointer low byte is a computed jump
		if (wr_f && (eff == `ECD_ADR_PCL)) begin
			jmp = 1'b1;
			tgt = pc_full(page, {1'b0, alu.y});
		end
	end

	// register write-back; the window with a zero pointer swallows writes
	assign core_we   = run_ff && wr_f && !is_sfr(eff);
	assign bus_we    = bus_wr && (bus_addr <= `ECD_BUS_MEM_TOP) && !is_sfr(bus_addr[4:0]) && !core_we;
	assign mem.we    = core_we || bus_we;
	assign mem.waddr = core_we ? eff : bus_addr[4:0];
	assign mem.wdata = core_we ? alu.y : bus_wdata;
	assign mem.baddr = bus_addr[4:0];

	assign nxt_w   = wr_w ? alu.y : w_ff;
	assign nxt_ptr = (wr_f && (eff == `ECD_ADR_PTR)) ? alu.y[4:0] : ptr_ff;
	assign nxt_ip  = jmp ? tgt : ip_inc;

	// flag update wins over a direct write of the status register
	always_comb begin
		nxt_stat = stat_ff;
		if (wr_f && (eff == `ECD_ADR_STAT)) begin
			nxt_stat = alu.y;
		end
		if (fl[0]) begin
			nxt_stat[`ECD_ST_C] = alu.c;
		end
		if (fl[1]) begin
			nxt_stat[`ECD_ST_DC] = alu.dc;
		end
		if (fl[2]) begin
			nxt_stat[`ECD_ST_Z] = alu.z;
		end
	end

	assign bus_val = (bus_addr <= `ECD_BUS_MEM_TOP) ?
		rd_loc(bus_addr[4:0], mem.brdata, ip_ff[7:0], stat_ff, ptr_ff) :
		(bus_addr == `ECD_BUS_CTRL) ? {7'h00, run_ff} :
		(bus_addr == `ECD_BUS_STATE) ? {7'h00, pipe_ff} : 8'h00;
	assign nxt_rdata = bus_rd ? bus_val : 8'h00;

	// pipeline: prefetched word is dropped on a flow change or skip
	always_ff @(posedge clk) begin
		if (rst) begin
			instr_ff <= `ECD_NOP;
			pipe_ff  <= ecd_pkg::ECD_PIPE_FLUSH;
			ip_ff    <= '1;
		end else if (run_ff) begin
			instr_ff <= prog_instr;
			pipe_ff  <= (jmp || skip) ? ecd_pkg::ECD_PIPE_FLUSH : ecd_pkg::ECD_PIPE_EXEC;
			ip_ff    <= nxt_ip;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			w_ff    <= 8'h00;
			stat_ff <= `ECD_STAT_RST;
			ptr_ff  <= `ECD_PTR_RST;
		end else if (run_ff) begin
			w_ff    <= nxt_w;
			stat_ff <= nxt_stat;
			ptr_ff  <= nxt_ptr;
		end
	end

	// two-deep return stack, oldest entry is copied on return
	always_ff @(posedge clk) begin
		if (rst) begin
			stk0_ff <= '0;
			stk1_ff <= '0;
		end else if (run_ff && push) begin
			stk0_ff <= ip_ff;
			stk1_ff <= stk0_ff;
		end else if (run_ff && pop) begin
			stk0_ff <= stk1_ff;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			run_ff    <= `ECD_CTRL_RST;
			bus_rdata <= 8'h00;
		end else begin
			bus_rdata <= nxt_rdata;
			if (bus_wr && (bus_addr == `ECD_BUS_CTRL)) begin
				run_ff <= bus_wdata[0];
			end
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	flush_on_jump_a: assert property (
		run_ff && jmp |=> pipe_ff == ecd_pkg::ECD_PIPE_FLUSH ##1 1'b1)
		else $error("flow change did not flush the prefetch");

	ip_step_a: assert property (
		run_ff && !jmp |=> ip_ff == $past(ip_inc))
		else $error("instruction pointer did not step by one");

	single_cycle_a: assert property (
		run_ff && !jmp && !skip |=> exec)
		else $error("plain instruction lost the next slot");

	prefetch_a: assert property (
		run_ff |=> instr_ff == $past(prog_instr))
		else $error("prefetched word not captured");

	alu_add_a: assert property (
		alu.op == ecd_pkg::ECD_ALU_ADD |-> {alu.c, alu.y} == {1'b0, alu.a} + {1'b0, alu.b} &&
		alu.dc == (({1'b0, alu.a[3:0]} + {1'b0, alu.b[3:0]}) > 5'h0f))
		else $error("add result or carries wrong");

	alu_sub_a: assert property (
		alu.op == ecd_pkg::ECD_ALU_SUB |-> alu.c == (alu.a >= alu.b) &&
		alu.dc == (alu.a[3:0] >= alu.b[3:0]) && alu.y == alu.a - alu.b)
		else $error("subtract borrow flags wrong");

	zero_flag_a: assert property (
		run_ff && fl[2] |=> stat_ff[`ECD_ST_Z] == ($past(alu.y) == 8'h00))
		else $error("zero flag does not follow result");

	pcl_write_a: assert property (
		run_ff && wr_f && eff == `ECD_ADR_PCL |=> ip_ff[7:0] == $past(alu.y) && !exec)
		else $error("pointer low byte write did not jump");

	indirect_a: assert property (
		exec && fsel == `ECD_ADR_INDW && !is_sfr(ptr_ff) |-> fdata == mem.rdata && mem.raddr == ptr_ff)
		else $error("window access not redirected");

	literal_load_a: assert property (
		run_ff && exec && instr_ff[11:8] == ecd_pkg::ECD_TOP_LOADLIT |=> w_ff == $past(lit))
		else $error("literal not loaded into accumulator");
endmodule

// ==== testbench/ecd_prog_rom.sv ====
// program storage model feeding the core's fetch port
module ecd_prog_rom #(
	parameter int AW = 9
) (
	input  wire logic [AW-1:0] addr,
	input  wire logic          rd_en,
	output logic [11:0]        instr
);
	timeunit 1ns;
	timeprecision 1ps;

	// every location starts as the empty instruction
	logic [11:0] words [2**AW] = '{default: 12'h000};
	logic [11:0] last_word     = 12'h000;

	task automatic load(input int a, input logic [11:0] w);
		words[a] = w;
	endtask

	// combinational read, one whole word per cycle
	// the word is inverted while idle, so a fetch without enable is never silently right
	always_comb begin
		if (rd_en) begin
			instr = words[addr];
		end else begin
			instr = ~last_word;
		end
	end

	always @(addr or rd_en) begin
		if (rd_en) begin
			last_word = words[addr];
		end
	end
endmodule

// ==== testbench/tb_eight_bit_core_datapath.sv ====
// self-checking bench for the eight-bit core datapath
module tb_eight_bit_core_datapath;
	timeunit 1ns;
	timeprecision 1ps;

	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [8:0]  prog_addr;
	logic        prog_rd_en;
	logic [11:0] prog_instr;
	logic [7:0]  bus_addr = 8'h00;
	logic [7:0]  bus_wdata = 8'h00;
	logic        bus_wr = 1'b0;
	logic        bus_rd = 1'b0;
	logic [7:0]  bus_rdata;
	int          num_errors = 0;
	int          n_tests = 0;

	always #12.5 clk = ~clk;

	ecd_core #(.PC_W(9)) dut_u (
		.clk        (clk),
		.rst        (rst),
		.prog_addr  (prog_addr),
		.prog_rd_en (prog_rd_en),
		.prog_instr (prog_instr),
		.bus_addr   (bus_addr),
		.bus_wdata  (bus_wdata),
		.bus_wr     (bus_wr),
		.bus_rd     (bus_rd),
		.bus_rdata  (bus_rdata)
	);

	ecd_prog_rom #(.AW(9)) prog_u (
		.addr  (prog_addr),
		.rd_en (prog_rd_en),
		.instr (prog_instr)
	);

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic end_sim();
		$display("checks %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic bus_read(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		bus_rd   <= 1'b1;
		bus_addr <= a;
		@(posedge clk);
		bus_rd <= 1'b0;
		#1;
		d = bus_rdata;
	endtask

	task automatic bus_write(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		bus_wr    <= 1'b1;
		bus_addr  <= a;
		bus_wdata <= d;
		@(posedge clk);
		bus_wr <= 1'b0;
	endtask

	// arithmetic, flag capture, indirect store, jump with a trap word behind it
	// the call at 0x101 is taken just as run is cleared; the routine at 0x80 runs after resume
	task automatic load_program();
		logic [11:0] prog [21];
		logic [11:0] sub [10];
		prog = '{12'hc3a, 12'h025, 12'hcc8, 12'h1e5, 12'h203, 12'h026, 12'hc10, 12'h027,
			12'hc01, 12'h0a7, 12'h203, 12'h028, 12'hf19, 12'h203, 12'h029, 12'hc0a,
			12'h024, 12'hc55, 12'h020, 12'hb00, 12'h02b};
		sub = '{12'hc80, 12'h02d, 12'h32d, 12'h38d, 12'h5ee, 12'h6ee, 12'h02f, 12'h7ee,
			12'h030, 12'h8a5};
		foreach (prog[i]) begin
			prog_u.load(i, prog[i]);
		end
		foreach (sub[i]) begin
			prog_u.load(9'h080 + i, sub[i]);
		end
		prog_u.load(9'h100, 12'h02c);
		prog_u.load(9'h101, 12'h980);
		prog_u.load(9'h102, 12'h031);
		prog_u.load(9'h103, 12'hb03);
	endtask

	// reset vector, then sequential fetch one word per cycle
	task automatic t_startup();
		#1;
		check("reset fetch address", 16'(prog_addr), 16'h01ff);
		check("fetch enable", 16'(prog_rd_en), 16'h0001);
		check("idle read data", 16'(bus_rdata), 16'h0000);
		@(posedge clk);
		#1;
		check("fetch wrap", 16'(prog_addr), 16'h0000);
		@(posedge clk);
		#1;
		check("fetch step", 16'(prog_addr), 16'h0001);
	endtask

	// reads of window, unmapped place and control while the core runs
	task automatic t_map_reads();
		logic [7:0] d;
		bus_read(8'h00, d);
		check("window by bus", 16'(d), 16'h0000);
		bus_read(8'h40, d);
		check("unmapped read", 16'(d), 16'h0000);
		bus_read(8'h20, d);
		check("control reset", 16'(d), 16'h0001);
		@(posedge clk);
		#1;
		check("read data one cycle", 16'(bus_rdata), 16'h0000);
	endtask

	// jump at 0x13: trap word flushed, empty slot flagged, target fetched
	task automatic t_branch();
		int n;
		n = 0;
		while (prog_addr !== 9'h014 && n < 40) begin
			@(posedge clk);
			#1;
			n++;
		end
		check("reach jump", 16'(prog_addr), 16'h0014);
		@(posedge clk);
		bus_rd   <= 1'b1;
		bus_addr <= 8'h21;
		#1;
		check("jump target", 16'(prog_addr), 16'h0100);
		@(posedge clk);
		bus_rd <= 1'b0;
		#1;
		check("flushed slot", 16'(bus_rdata), 16'h0001);
		check("after target", 16'(prog_addr), 16'h0101);
	endtask

	// clearing run freezes the fetch address
	task automatic t_freeze();
		logic [8:0] held;
		bus_write(8'h20, 8'h00);
		@(posedge clk);
		#1;
		held = prog_addr;
		check("fetch off", 16'(prog_rd_en), 16'h0000);
		repeat (4) @(posedge clk);
		#1;
		check("frozen address", 16'(prog_addr), 16'(held));
	endtask

	// results of the program, read back through the data map
	task automatic t_results();
		logic [7:0] d;
		logic [7:0] adr [9] = '{8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0a, 8'h04, 8'h0b, 8'h0c};
		logic [7:0] exp [9] = '{8'h02, 8'h1b, 8'h0f, 8'h19, 8'h1d, 8'h55, 8'hea, 8'h00, 8'h55};
		// sums, borrows and zero as captured status, indirect cell, pointer, trap cell, target cell
		foreach (adr[i]) begin
			bus_read(adr[i], d);
			check($sformatf("cell %h", adr[i]), 16'(d), 16'(exp[i]));
		end
	endtask

	// plain cell write, ignored writes to pointer and unmapped place
	task automatic t_bus_writes();
		logic [7:0] d;
		bus_write(8'h1f, 8'ha5);
		bus_read(8'h1f, d);
		check("plain cell", 16'(d), 16'h00a5);
		bus_write(8'h04, 8'h13);
		bus_read(8'h04, d);
		check("pointer write ignored", 16'(d), 16'h00ea);
		bus_write(8'h40, 8'h77);
		bus_read(8'h40, d);
		check("unmapped write", 16'(d), 16'h0000);
	endtask

	// resume: routine entered by the earlier call, rotate through carry, swap, bit set, both skips, return with literal
	task automatic t_resume();
		logic [7:0] d;
		logic [7:0] adr [6] = '{8'h0d, 8'h0f, 8'h0e, 8'h10, 8'h11, 8'h03};
		logic [7:0] exp [6] = '{8'hc0, 8'h0c, 8'h80, 8'h00, 8'ha5, 8'h18};
		// rotated cell, swapped copy, set bit, skipped trap cell, return literal, carry out of shift
		bus_write(8'h20, 8'h01);
		repeat (40) @(posedge clk);
		foreach (adr[i]) begin
			bus_read(adr[i], d);
			check($sformatf("cell %h", adr[i]), 16'(d), 16'(exp[i]));
		end
	endtask

	initial begin
		#(25 * 3000);
		num_errors++;
		$display("ERROR watchdog expected finish seen hang");
		end_sim();
	end

	initial begin
		load_program();
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		t_startup();
		t_map_reads();
		t_branch();
		t_freeze();
		t_results();
		t_bus_writes();
		t_resume();
		end_sim();
	end
endmodule
